/* File: gex_expander.sv */
// Eight-pin port expander with serial slave and change interrupt.
// Assumes rst comes from a power-on detector; bus lines and pins are async.
// Function
// - Reset holds all logic, then defaults
// - All pins inputs after reset
// - Input pins: both drivers off
// - Output pins: one driver per latch
// - Input edge raises change interrupt
// - Return to captured levels clears interrupt
// - Port read clears interrupt at ack
// - Change during ack pulse may vanish
// - Later changes raise interrupt again
// - Foreign writes, output pins: no interrupt
// - Output-to-input switch may falsely interrupt
// - Interrupt output open drain, low active
// - Pointer zero plus foreign read clears
// - Start and stop detected while clock high
// - Matching address acknowledged low on data
// - One bit per clock, stable high
// - Eight-bit bytes, each with ack bit
// - Device acks every byte it receives
// - Master nack ends read; release data
// - Pointer low bits pick register
// - Direction one input, zero output
// - Input register shows pins; writes ignored
// - Polarity bit inverts returned level
`timescale 1ns/100ps
module gex_expander
#(
    parameter int PINS = 8
)
(
    input  wire logic            clk_sys,
    input  wire logic            rst,
    input  wire logic            scl_in,
    input  wire logic            sda_in,
    output logic                 sda_out,
    output logic                 sda_oe,
    input  wire logic [2:0]      addr_select_pins,
    input  wire logic [PINS-1:0] port_pins_in,
    output logic      [PINS-1:0] high_side_driver,
    output logic      [PINS-1:0] low_side_driver,
    output logic                 int_n_out,
    output logic                 int_n_oe
);
    // ==========================================================
    // Elaboration check
    if (PINS != gex_pkg::BYTE_BITS)
    begin : g_bad_width
        $error("Port width must equal one serial byte");
    end

    // ==========================================================
    // Input synchronisers
    logic [1:0]      bus_s;     // Synced clock and data
    logic [PINS-1:0] pin_s;     // Synced port levels
    logic [2:0]      strap_s;   // Synced address straps

    gex_sync #(.WIDTH(2), .INIT(2'h3)) u_bus_sync
    (
        .clk_sys (clk_sys),
        .rst     (rst),
        .din     ({scl_in, sda_in}),
        .dout    (bus_s)
    );

    gex_sync #(.WIDTH(PINS + 3), .INIT('0)) u_pin_sync
    (
        .clk_sys (clk_sys),
        .rst     (rst),
        .din     ({addr_select_pins, port_pins_in}),
        .dout    ({strap_s, pin_s})
    );

    // ==========================================================
    // Edge and condition decode
    logic scl_d;                 // Previous synced clock
    logic sda_d;                 // Previous synced data
    wire  scl_now   = bus_s[1];
    wire  sda_now   = bus_s[0];
    wire  scl_rise  = scl_now & ~scl_d;
    wire  scl_fall  = ~scl_now & scl_d;
    wire  start_det = scl_now & scl_d & sda_d & ~sda_now;
    wire  stop_det  = scl_now & scl_d & ~sda_d & sda_now;

    // History of bus lines
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end
        else
        begin
            scl_d <= scl_now;
            sda_d <= sda_now;
        end
    end

    // ==========================================================
    // Registers and serial engine state
    gex_pkg::gex_state_e state;       // Engine state
    gex_pkg::gex_state_e next_state;  // Engine next state
    logic [7:0] shreg;        // Shift register, MSB first
    logic [3:0] bitcnt;       // Bits of current byte
    logic       first_wr;     // Next written byte is command
    logic       acking;       // Device pulls data low this slot: ack or read zero bit
    logic       foreign_rd;   // Another slave took a read
    logic [7:0] cmd;          // Register pointer
    logic [7:0] out_reg;      // Output latch
    logic [7:0] pol_reg;      // Polarity inversion
    logic [7:0] dir_reg;      // Direction, 1 is input
    logic [7:0] ref_reg;      // Captured input reference
    logic       irq;          // Change interrupt pending

    // Input register view, polarity applied
    wire [7:0] in_view  = pin_s ^ pol_reg;
    wire       addr_hit = (shreg[7:4] == gex_pkg::ADDR_FIXED)
                          & (shreg[3:1] == strap_s);
    wire [1:0] ptr      = cmd[1:0];

    // Selected register for readback
    wire [7:0] rd_sel   = (ptr == gex_pkg::PTR_INPUT)    ? in_view :
                          (ptr == gex_pkg::PTR_OUTPUT)   ? out_reg :
                          (ptr == gex_pkg::PTR_POLARITY) ? pol_reg : dir_reg;

    wire byte_done = scl_fall & (bitcnt == gex_pkg::BIT_LAST);
    // Ack slot rise during our read of the input register
    wire rd_ack_rise = (state == gex_pkg::GEX_RACK) & scl_rise
                       & (ptr == gex_pkg::PTR_INPUT);
    // Pointer zero and a foreign read address was acknowledged
    wire bug_clear   = foreign_rd & scl_rise & ~sda_now
                       & (cmd == gex_pkg::CMD_RST);
    wire irq_clear   = rd_ack_rise | bug_clear;
    // Input-mode pins differing from reference
    wire [7:0] diff  = (pin_s ^ ref_reg) & dir_reg;

    // ==========================================================
    // Next-state decode
    always_comb
    begin
        next_state = state;
        unique case (state)
            gex_pkg::GEX_IDLE: next_state = gex_pkg::GEX_IDLE;
            gex_pkg::GEX_ADDR:
            begin
                if (byte_done)
                begin
                    // Unmatched address: go quiet until next start
                    next_state = addr_hit ? gex_pkg::GEX_AACK : gex_pkg::GEX_IDLE;
                end
            end
            gex_pkg::GEX_AACK:
            begin
                if (scl_fall)
                begin
                    next_state = shreg[0] ? gex_pkg::GEX_RD : gex_pkg::GEX_WR;
                end
            end
            gex_pkg::GEX_WR:   next_state = byte_done ? gex_pkg::GEX_WACK : gex_pkg::GEX_WR;
            gex_pkg::GEX_WACK: next_state = scl_fall ? gex_pkg::GEX_WR : gex_pkg::GEX_WACK;
            gex_pkg::GEX_RD:   next_state = byte_done ? gex_pkg::GEX_RACK : gex_pkg::GEX_RD;
            gex_pkg::GEX_RACK:
            begin
                if (scl_rise)
                begin
                    // Master nack ends read and releases the line
                    next_state = sda_now ? gex_pkg::GEX_IDLE : gex_pkg::GEX_RACK;
                end
                else if (scl_fall)
                begin
                    next_state = gex_pkg::GEX_RD;
                end
            end
            default: next_state = gex_pkg::GEX_IDLE;
        endcase
        if (start_det)
        begin
            next_state = gex_pkg::GEX_ADDR;
        end
        else if (stop_det)
        begin
            next_state = gex_pkg::GEX_IDLE;
        end
    end

    // ==========================================================
    // Engine state and bit counting
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state  <= gex_pkg::GEX_IDLE;
            bitcnt <= 4'h0;
        end
        else
        begin
            state <= next_state;
            // Restarts after each ack slot; a start loads all ones so the
            // start's own clock fall wraps it to zero instead of counting
            if (start_det || (scl_fall && (bitcnt == gex_pkg::BIT_LAST + 4'h1)))
            begin
                bitcnt <= start_det ? 4'hf : 4'h0;
            end
            else if (scl_fall && state != gex_pkg::GEX_IDLE)
            begin
                bitcnt <= bitcnt + 4'h1;
            end
        end
    end

    // ==========================================================
    // Shift register: sample on rise, load read data at ack end
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            shreg <= 8'h00;
        end
        else if (scl_fall && ((state == gex_pkg::GEX_AACK && shreg[0])
                 || (state == gex_pkg::GEX_RACK)))
        begin
            shreg <= rd_sel;
        end
        else if (scl_fall && state == gex_pkg::GEX_RD && bitcnt != gex_pkg::BIT_LAST)
        begin
            shreg <= {shreg[6:0], 1'b0};
        end
        else if (scl_rise && (state == gex_pkg::GEX_ADDR || state == gex_pkg::GEX_WR))
        begin
            shreg <= {shreg[6:0], sda_now};
        end
    end

    // ==========================================================
    // Foreign read tracking for the pointer-zero defect
    always_ff @(posedge clk_sys)
    begin
        if (rst || start_det || stop_det)
        begin
            foreign_rd <= 1'b0;
        end
        else if (byte_done && state == gex_pkg::GEX_ADDR)
        begin
            foreign_rd <= ~addr_hit & shreg[0];
        end
        else if (scl_fall && foreign_rd)
        begin
            foreign_rd <= 1'b0;
        end
    end

    // ==========================================================
    // Command and register writes
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            cmd      <= gex_pkg::CMD_RST;
            out_reg  <= gex_pkg::OUTPUT_RST;
            pol_reg  <= gex_pkg::POLARITY_RST;
            dir_reg  <= gex_pkg::DIR_RST;
            first_wr <= 1'b0;
        end
        else if (state == gex_pkg::GEX_AACK)
        begin
            first_wr <= 1'b1;
        end
        else if (byte_done && state == gex_pkg::GEX_WR)
        begin
            first_wr <= 1'b0;
            if (first_wr)
            begin
                cmd <= shreg;
            end
            else
            begin
                // Input register writes fall through untouched
                unique case (ptr)
                    gex_pkg::PTR_INPUT:    cmd <= cmd;
                    gex_pkg::PTR_OUTPUT:   out_reg <= shreg;
                    gex_pkg::PTR_POLARITY: pol_reg <= shreg;
                    gex_pkg::PTR_DIR:      dir_reg <= shreg;
                endcase
            end
        end
    end

    // ==========================================================
    // Data line drive: ack slots and read bits
    wire want_ack  = (state == gex_pkg::GEX_AACK) | (state == gex_pkg::GEX_WACK);
    wire want_bit0 = (state == gex_pkg::GEX_RD) & ~shreg[7];

    // Change drive only while clock is low; a start or stop clears it at once
    always_ff @(posedge clk_sys)
    begin
        if (rst || start_det || stop_det)
        begin
            acking <= 1'b0;
        end
        else if (!scl_now)
        begin
            acking <= want_ack | want_bit0;
        end
    end

    // ==========================================================
    // Change interrupt and reference capture
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            ref_reg <= 8'h00;
            irq     <= 1'b0;
        end
        else if (irq_clear)
        begin
            // Edge landing here is lost, as with the ack pulse
            ref_reg <= pin_s;
            irq     <= 1'b0;
        end
        else if (!irq)
        begin
            // Reference freezes on a change so a return can clear it
            ref_reg <= (|diff) ? ref_reg : pin_s;
            irq     <= |diff;
        end
        else if (~|diff)
        begin
            irq <= 1'b0;
        end
    end

    // ==========================================================
    // Registered outputs
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            sda_out          <= 1'b0;
            sda_oe           <= 1'b0;
            high_side_driver <= '0;
            low_side_driver  <= '0;
            int_n_out        <= 1'b0;
            int_n_oe         <= 1'b0;
        end
        else
        begin
            sda_oe           <= acking;
            high_side_driver <= ~dir_reg & out_reg;
            low_side_driver  <= ~dir_reg & ~out_reg;
            int_n_oe         <= irq;
        end
    end
endmodule

/* File: gex_pkg.sv */
// Shared constants for the serial-controlled eight-pin port expander.
// Assumes one 50 MHz system clock; no other file defines these names.
package gex_pkg;
    // ==========================================================
    // Register pointer codes
    localparam logic [1:0] PTR_INPUT    = 2'h0;
    localparam logic [1:0] PTR_OUTPUT   = 2'h1;
    localparam logic [1:0] PTR_POLARITY = 2'h2;
    localparam logic [1:0] PTR_DIR      = 2'h3;
    // ==========================================================
    // Reset values
    localparam logic [7:0] OUTPUT_RST   = 8'hff;
    localparam logic [7:0] POLARITY_RST = 8'h00;
    localparam logic [7:0] DIR_RST      = 8'hff;
    localparam logic [7:0] CMD_RST      = 8'h00;
    // ==========================================================
    // Fixed upper address bits, then three strap bits
    localparam logic [3:0] ADDR_FIXED   = 4'h7;
    localparam int         BYTE_BITS    = 8;
    localparam logic [3:0] BIT_LAST     = 4'h7;
    // ==========================================================
    // Serial engine states
    typedef enum logic [2:0]
    {
        GEX_IDLE  = 3'b000,
        GEX_ADDR  = 3'b001,
        GEX_AACK  = 3'b010,
        GEX_WR    = 3'b011,
        GEX_WACK  = 3'b100,
        GEX_RD    = 3'b101,
        GEX_RACK  = 3'b110
    } gex_state_e;
endpackage

/* File: gex_sync.sv */
// Two-flop synchroniser for a group of asynchronous levels.
// Assumes inputs may change at any time relative to clk_sys.
`timescale 1ns/100ps
module gex_sync
#(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
)
(
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    // ==========================================================
    // Metastability stages
    logic [WIDTH-1:0] meta;   // First stage, read only by second

    // Both stages reset to idle level
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            meta <= INIT;
            dout <= INIT;
        end
        else
        begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule

/* File: gex_expander_monitor.sv */
// Port-level checks for the eight-pin port expander.
// Assumes it is bound to the expander and sees only its ports.
`timescale 1ns/100ps
module gex_expander_monitor
#(
    parameter int PINS = 8
)
(
    input wire logic            clk_sys,
    input wire logic            rst,
    input wire logic            scl_in,
    input wire logic            sda_in,
    input wire logic            sda_out,
    input wire logic            sda_oe,
    input wire logic [2:0]      addr_select_pins,
    input wire logic [PINS-1:0] port_pins_in,
    input wire logic [PINS-1:0] high_side_driver,
    input wire logic [PINS-1:0] low_side_driver,
    input wire logic            int_n_out,
    input wire logic            int_n_oe
);
    // ==========================================================
    // One clock domain, synchronous reset
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Pins that some driver currently holds
    wire logic [PINS-1:0] driven = high_side_driver | low_side_driver;
    // ==========================================================
    // Interrupt raising
    // Edge on an all-input port while nothing is pending
    sequence s_pin_edge;
        $changed(port_pins_in) && driven == '0 && !int_n_oe;
    endsequence
    // No further pin edge and no bus clock, so nothing may clear it
    sequence s_quiet;
        ($stable(port_pins_in) && $stable(scl_in)) [*7];
    endsequence
    chk_int_on_change: assert property
        (s_pin_edge ##1 s_quiet |-> int_n_oe)
        else $error("interrupt missing after input edge");
    chk_out_no_int: assert property
        ((&driven) [*8] ##0 !int_n_oe |=> !int_n_oe)
        else $error("interrupt raised with all pins driven");
    // ==========================================================
    // Pin drivers and open-drain outputs
    chk_drv_exclusive: assert property
        ((high_side_driver & low_side_driver) == '0)
        else $error("pin driven high and low together");
    chk_reset_quiet: assert property
        ($fell(rst) |-> driven == '0 && !sda_oe && !int_n_oe)
        else $error("outputs active right after reset");
    chk_int_open_drain: assert property
        (int_n_oe |-> !int_n_out)
        else $error("interrupt line driven high");
    // ==========================================================
    // Serial data line discipline
    chk_sda_open_drain: assert property
        (sda_oe |-> !sda_out)
        else $error("data line driven high");
    chk_oe_stable_high: assert property
        (scl_in [*5] |-> $stable(sda_oe))
        else $error("data drive changed while clock high");
    chk_ack_rise_low: assert property
        ($rose(sda_oe) |-> !scl_in && !$past(scl_in))
        else $error("data drive started outside clock low");
    // ==========================================================
    // Clock high longer than any bit or start phase: bus is idle.
    // Limit assumes a master high phase well under this count.
    localparam int IDLE_HIGH = 32;
    logic [5:0] scl_high_cnt;   // Saturating count of clock-high cycles
    always_ff @(posedge clk_sys)
    begin
        if (rst || !scl_in)
        begin
            scl_high_cnt <= 6'h00;
        end
        else if (scl_high_cnt != 6'h3f)
        begin
            scl_high_cnt <= scl_high_cnt + 6'h01;
        end
    end
    chk_idle_release: assert property
        (scl_high_cnt >= IDLE_HIGH |-> !sda_oe)
        else $error("data line held after transfer");
endmodule
bind gex_expander gex_expander_monitor #(.PINS(PINS)) u_monitor
(
    .clk_sys          (clk_sys),
    .rst              (rst),
    .scl_in           (scl_in),
    .sda_in           (sda_in),
    .sda_out          (sda_out),
    .sda_oe           (sda_oe),
    .addr_select_pins (addr_select_pins),
    .port_pins_in     (port_pins_in),
    .high_side_driver (high_side_driver),
    .low_side_driver  (low_side_driver),
    .int_n_out        (int_n_out),
    .int_n_oe         (int_n_oe)
);

/* File: gex_bus_master.sv */
// Behavioural two-wire bus master, plus one other slave's ack.
// Assumes the bench resolves the lines with pull-ups.
`timescale 1ns/100ps
module gex_bus_master
(
    input  wire logic clk_sys,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low,
    output logic      other_low
);
    // Quarter bit in system clocks; raise it for a slow master
    int quarter = 4;
    // ==========================================================
    // Idle bus: clock high, data released
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
        other_low = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // One bit: data set in low phase, sampled mid high phase
    task automatic bit_slot(input logic b, output logic s);
        sda_low <= ~b;
        wt(quarter);
        scl <= 1'b1;
        wt(quarter);
        s = sda;
        wt(quarter);
        scl <= 1'b0;
        wt(quarter);
    endtask
    // Start or repeated start: data falls while clock high
    task automatic start();
        sda_low <= 1'b0;
        wt(quarter);
        scl <= 1'b1;
        wt(2 * quarter);
        sda_low <= 1'b1;
        wt(2 * quarter);
        scl <= 1'b0;
        wt(quarter);
    endtask
    // Stop: data rises while clock high, clock then stays high
    task automatic stop();
        sda_low <= 1'b1;
        wt(quarter);
        scl <= 1'b1;
        wt(2 * quarter);
        sda_low <= 1'b0;
        wt(2 * quarter);
    endtask
    // Byte out, then released ack slot; fk lets another slave ack
    task automatic wbyte(input logic [7:0] d, input logic fk, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_slot(d[i], s);
        other_low <= fk;
        bit_slot(1'b1, s);
        other_low <= 1'b0;
        ack = ~s;
    endtask
    // Byte in; ack all but the last, which ends the read
    task automatic rbyte(input logic mack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_slot(1'b1, d[i]);
        bit_slot(~mack, s);
    endtask
endmodule

/* File: gex_expander_tb_top.sv */
// Self-checking bench for the port expander over its two-wire port.
// Assumes gex_pkg, the expander, its monitor and the bus master model.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module gex_expander_tb_top;
    // ==========================================================
    // Stimulus and resolved lines
    logic            clk_sys = 1'b0;
    logic            rst = 1'b1;
    logic [2:0]      straps = 3'h5;
    logic [7:0]      pin_ext = 8'h00;
    logic [7:0]      rd_data;
    logic            ack;
    int              n_fail = 0;
    int              comparisons = 0;
    wire logic       scl, m_low, o_low, sda_oe, sda_out, int_n_oe, int_n_out;
    wire logic [7:0] hs, ls;
    // Open-drain lines with pull-ups
    wire logic       sda = !(m_low || o_low || (sda_oe && !sda_out));
    wire logic       int_n = !(int_n_oe && !int_n_out);
    // Driven pins follow their driver, the rest the outside level
    wire logic [7:0] pins = (pin_ext & ~ls) | hs;
    wire logic [6:0] dev = {gex_pkg::ADDR_FIXED, straps};
    always #10 clk_sys = ~clk_sys;
    gex_expander #(.PINS(8)) uut
    (
        .clk_sys          (clk_sys),
        .rst              (rst),
        .scl_in           (scl),
        .sda_in           (sda),
        .sda_out          (sda_out),
        .sda_oe           (sda_oe),
        .addr_select_pins (straps),
        .port_pins_in     (pins),
        .high_side_driver (hs),
        .low_side_driver  (ls),
        .int_n_out        (int_n_out),
        .int_n_oe         (int_n_oe)
    );
    gex_bus_master m
    (
        .clk_sys   (clk_sys),
        .sda       (sda),
        .scl       (scl),
        .sda_low   (m_low),
        .other_low (o_low)
    );
    // ==========================================================
    // Access tasks
    task automatic wr(input logic [1:0] p, input logic [7:0] d);
        m.start();
        m.wbyte({dev, 1'b0}, 1'b0, ack);
        `CHK("addr ack", 1'b1, ack)
        m.wbyte({6'h00, p}, 1'b0, ack);
        `CHK("cmd ack", 1'b1, ack)
        m.wbyte(d, 1'b0, ack);
        `CHK("data ack", 1'b1, ack)
        m.stop();
    endtask
    // Pointer write, restart, two bytes read, last one refused
    task automatic rd(input logic [1:0] p, input logic [7:0] e);
        m.start();
        m.wbyte({dev, 1'b0}, 1'b0, ack);
        m.wbyte({6'h00, p}, 1'b0, ack);
        m.start();
        m.wbyte({dev, 1'b1}, 1'b0, ack);
        m.rbyte(1'b1, rd_data);
        `CHK("read first", e, rd_data)
        m.rbyte(1'b0, rd_data);
        `CHK("read last", e, rd_data)
        m.stop();
    endtask
    // New outside level, then interrupt line after it settles
    task automatic pin(input logic [7:0] v, input logic irq);
        pin_ext <= v;
        repeat (12) @(posedge clk_sys);
        `CHK("int_n", !irq, int_n)
    endtask
    // Address-only access to another slave that acks it
    task automatic other(input logic rw);
        m.start();
        m.wbyte({7'h50, rw}, 1'b1, ack);
        m.stop();
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ==========================================================
    // Test sequence
    initial
    begin
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        `CHK("high drv", 8'h00, hs)
        `CHK("low drv", 8'h00, ls)
        rd(gex_pkg::PTR_OUTPUT, gex_pkg::OUTPUT_RST);
        rd(gex_pkg::PTR_POLARITY, gex_pkg::POLARITY_RST);
        rd(gex_pkg::PTR_DIR, gex_pkg::DIR_RST);
        m.start();
        m.wbyte({gex_pkg::ADDR_FIXED, 3'h2, 1'b0}, 1'b0, ack);
        `CHK("wrong addr ack", 1'b0, ack)
        m.stop();
        $display("defaults done");
        // Upper nibble driven, lower nibble inputs
        wr(gex_pkg::PTR_OUTPUT, 8'ha5);
        wr(gex_pkg::PTR_DIR, 8'h0f);
        `CHK("high drv", 8'ha0, hs)
        `CHK("low drv", 8'h50, ls)
        pin(8'h06, 1'b1);
        rd(gex_pkg::PTR_INPUT, 8'ha6);
        wr(gex_pkg::PTR_INPUT, 8'h00);
        wr(gex_pkg::PTR_POLARITY, 8'hff);
        rd(gex_pkg::PTR_INPUT, 8'h59);
        wr(gex_pkg::PTR_POLARITY, 8'h00);
        $display("ports done");
        // Outside level matches before pins turn to inputs
        pin(8'ha6, 1'b0);
        wr(gex_pkg::PTR_DIR, 8'hff);
        rd(gex_pkg::PTR_INPUT, 8'ha6);
        pin(8'ha7, 1'b1);
        pin(8'ha6, 1'b0);
        pin(8'h26, 1'b1);
        rd(gex_pkg::PTR_INPUT, 8'h26);
        `CHK("int_n", 1'b1, int_n)
        pin(8'h27, 1'b1);
        // Pointer still zero: read of another slave clears wrongly
        other(1'b1);
        `CHK("int_n", 1'b1, int_n)
        rd(gex_pkg::PTR_INPUT, 8'h27);
        wr(gex_pkg::PTR_DIR, 8'hff);
        pin(8'h25, 1'b1);
        other(1'b1);
        `CHK("int_n", 1'b0, int_n)
        other(1'b0);
        `CHK("int_n", 1'b0, int_n)
        $display("interrupt done");
        // All pins driven: latch changes never interrupt
        rd(gex_pkg::PTR_INPUT, 8'h25);
        wr(gex_pkg::PTR_DIR, 8'h00);
        wr(gex_pkg::PTR_OUTPUT, 8'h5a);
        `CHK("low drv", 8'ha5, ls)
        pin(8'h00, 1'b0);
        m.quarter = 6;
        rd(gex_pkg::PTR_INPUT, 8'h5a);
        m.quarter = 4;
        $display("outputs done");
        end_of_test();
    end
    // Hang guard, well past the roughly 13k cycles the tests need
    initial
    begin
        repeat (80000) @(posedge clk_sys);
        n_fail++;
        $display("BAD watchdog exp done got hang");
        end_of_test();
    end
endmodule
